/* File: include/mspd_pkg.sv */
package mspd_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned TIMER_CLK_HZ = 32_000_000;
  localparam int unsigned HZ_PER_MHZ = 1_000_000;
  localparam int unsigned PERIOD_US = 2000;
  localparam int unsigned PERIOD_CYC = TIMER_CLK_HZ / HZ_PER_MHZ * PERIOD_US;
  localparam int unsigned TICKS_PER_STEP = 250;
  localparam int unsigned DUTY_INIT_PCT = 10;
  localparam int unsigned DUTY_STEP_PCT = 20;
  localparam int unsigned PCT_FULL = 100;
  localparam int unsigned DUTY_LAST_IDX = 4;

  // ****************************************
  // Widths
  // ****************************************
  localparam int CNT_W = 16;
  localparam int TICK_W = 8;
  localparam int IDX_W = 3;
  localparam int DIR_W = 8;
  localparam int IRQ_W = 2;
  localparam int ADDR_W = 8;

  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_PORT_DIR = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_COMPARE = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_TICKS = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 8'h1C;
  localparam int CTRL_START_M = 0;
  localparam int CTRL_START_S = 1;
  localparam int CTRL_STOP = 2;
  localparam int IRQ_TICK = 0;
  localparam int IRQ_STEP = 1;
  localparam int DIR_IND_BIT = 0;
  localparam int DIR_PWM_BIT = 6;
  localparam logic [DIR_W-1:0] DIR_RESET = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic {MSPD_IDLE, MSPD_RUN} mspd_run_e;

  typedef struct packed {
    logic start;
    logic stop;
    logic [CNT_W-1:0] load;
  } mspd_chan_ctl_s;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic busy;
    logic tick;
    logic out;
  } mspd_chan_st_s;

endpackage

/* File: rtl/mspd_chan.sv */
`timescale 1ns/1ps
// One timer channel: interval reload or one-count shot
module mspd_chan
  import mspd_pkg::*;
#(
  parameter bit ONE_COUNT = 1'b0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire mspd_chan_ctl_s ctl,
  input wire logic trig,
  // State
  output mspd_chan_st_s st
);

  mspd_chan_st_s s_reg;
  mspd_chan_st_s s_next;

  // ****************************************
  // Counter
  // ****************************************
  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (ctl.stop) begin
      s_next.busy = 1'b0;
      s_next.out = 1'b0;
      s_next.count = '0;
    end else if (ctl.start || (ONE_COUNT && trig)) begin
      // Restart is valid mid-count, so each trigger opens a fresh pulse
      s_next.count = ctl.load - 16'h0001;
      s_next.busy = 1'b1;
      s_next.out = ONE_COUNT;
    end else if (s_reg.busy) begin
      if (s_reg.count == '0) begin
        s_next.tick = 1'b1;
        if (ONE_COUNT) begin
          s_next.busy = 1'b0;
          s_next.out = 1'b0;
        end else begin
          s_next.count = ctl.load - 16'h0001;
        end
      end else begin
        s_next.count = s_reg.count - 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign st = s_reg;

  // ****************************************
  // Checks
  // ****************************************
  AST_CHAN_RELOAD: assert property (@(posedge pclk) disable iff (!presetn) // RL3
    (s_reg.busy && s_reg.count == '0 && !ctl.stop && !ctl.start && !trig)
      |=> (s_reg.tick && (ONE_COUNT ? !s_reg.busy : s_reg.count == $past(ctl.load) - 16'h0001)))
    else $error("Channel did not expire or reload correctly");

endmodule

/* File: rtl/mspd_top.sv */
`timescale 1ns/1ps
// What this block does
// (RL1) Master channel periods, slave channel sets width
// (RL2) PWM drives out on slave output pin
// (RL3) Master interval timer period is 2 ms
// (RL4) Slave one-count, restarted by master each period
// (RL5) Duty starts at 10 percent before running
// (RL6) Start only with both start bits together
// (RL7) Master raises tick event every 2 ms
// (RL8) Every 250 ticks duty rises 20 points
// (RL9) Duty steps 10..90 then wraps to 10
// (RL10) Duty change loads new slave compare value
// (RL11) Indicator output inverts at every step
// (RL12) Compare 0x1900 equals 10 percent duty
// (RL13) Direction bit 0 enables output buffer
// (RL14) Timer logic clocked at 32 MHz
// (RL15) Period 64000 cycles, compare is fraction thereof
// (RL16) Tick counter clears at 250
module mspd_top
  import mspd_pkg::*;
#(
  parameter int unsigned PERIOD = PERIOD_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  output logic pwm_port_pin,
  output logic pwm_port_pin_oe,
  output logic indicator_port_pin,
  output logic indicator_port_pin_oe,
  // Interrupt
  output logic irq
);

  // ****************************************
  // Duty table
  // ****************************************
  function automatic logic [CNT_W-1:0] compare_of(input logic [IDX_W-1:0] idx);
    int unsigned pct;
    pct = DUTY_INIT_PCT + DUTY_STEP_PCT * int'(idx);
    return CNT_W'(PERIOD * pct / PCT_FULL); // RL15 RL12
  endfunction

  localparam logic [CNT_W-1:0] COMPARE_RESET = compare_of(3'h0);
  localparam logic [CNT_W-1:0] PERIOD_LOAD = CNT_W'(PERIOD); // RL3 RL14
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICKS_PER_STEP - 1);
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(DUTY_LAST_IDX);

  typedef struct packed {
    mspd_run_e run;
    logic start_p;
    logic stop_p;
    logic [TICK_W-1:0] tick_cnt;
    logic [IDX_W-1:0] duty_idx;
    logic [CNT_W-1:0] compare;
    logic ind;
    logic [IRQ_W-1:0] stat;
    logic [IRQ_W-1:0] mask;
    logic [DIR_W-1:0] dir;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic pwm;
    logic pwm_oe;
    logic ind_oe;
    logic irq;
  } mspd_state_s;

  mspd_state_s s_reg;
  mspd_state_s s_next;

  mspd_chan_ctl_s m_ctl;
  mspd_chan_ctl_s sl_ctl;
  mspd_chan_st_s m_st;
  mspd_chan_st_s sl_st;
  logic sl_trig;
  logic access;
  logic wr_en;
  logic hit;
  logic [31:0] rd_val;

  // ****************************************
  // Channel pair
  // ****************************************
  assign m_ctl = '{start: s_reg.start_p, stop: s_reg.stop_p, load: PERIOD_LOAD};
  assign sl_ctl = '{start: s_reg.start_p, stop: s_reg.stop_p, load: s_reg.compare};
  // Slave restarts from the master's expiry only while running
  assign sl_trig = m_st.tick && (s_reg.run == MSPD_RUN); // RL4

  mspd_chan #(
    .ONE_COUNT(1'b0)
  ) u_master ( // RL1
    .pclk(pclk),
    .presetn(presetn),
    .ctl(m_ctl),
    .trig(1'b0),
    .st(m_st)
  );

  mspd_chan #(
    .ONE_COUNT(1'b1)
  ) u_slave ( // RL1
    .pclk(pclk),
    .presetn(presetn),
    .ctl(sl_ctl),
    .trig(sl_trig),
    .st(sl_st)
  );

  // ****************************************
  // APB decode
  // ****************************************
  assign access = psel && penable;
  assign wr_en = access && s_reg.pready && pwrite && !s_reg.pslverr;

  always_comb begin
    hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      ADDR_CTRL: rd_val[0] = (s_reg.run == MSPD_RUN);
      ADDR_STATUS: rd_val = {27'h000_0000, s_reg.ind, s_reg.duty_idx,
                             s_reg.run == MSPD_RUN};
      ADDR_IRQ_STAT: rd_val[IRQ_W-1:0] = s_reg.stat;
      ADDR_IRQ_MASK: rd_val[IRQ_W-1:0] = s_reg.mask;
      ADDR_PORT_DIR: rd_val[DIR_W-1:0] = s_reg.dir;
      ADDR_COMPARE: rd_val[CNT_W-1:0] = s_reg.compare;
      ADDR_TICKS: rd_val[TICK_W-1:0] = s_reg.tick_cnt;
      ADDR_COUNT: rd_val[CNT_W-1:0] = m_st.count;
      default: hit = 1'b0;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_next = s_reg;
    s_next.start_p = 1'b0;
    s_next.stop_p = 1'b0;
    s_next.pready = 1'b0;
    s_next.pslverr = 1'b0;

    // One wait state so read data leaves a flop
    if (access && !s_reg.pready) begin
      s_next.pready = 1'b1;
      s_next.pslverr = !hit;
      s_next.prdata = hit ? rd_val : 32'h0000_0000;
    end

    if (wr_en) begin
      case (paddr)
        ADDR_CTRL: begin
          if (pwdata[CTRL_STOP]) begin
            s_next.stop_p = 1'b1;
            s_next.run = MSPD_IDLE;
          end else if (pwdata[CTRL_START_M] && pwdata[CTRL_START_S]) begin // RL6
            s_next.start_p = 1'b1;
            s_next.run = MSPD_RUN;
            s_next.tick_cnt = '0;
          end
        end
        ADDR_IRQ_STAT: s_next.stat = s_reg.stat & ~pwdata[IRQ_W-1:0];
        ADDR_IRQ_MASK: s_next.mask = pwdata[IRQ_W-1:0];
        ADDR_PORT_DIR: s_next.dir = pwdata[DIR_W-1:0];
        default: s_next.run = s_reg.run;
      endcase
    end

    // Sets come after the clear so a same-cycle event survives
    case (s_reg.run)
      MSPD_RUN: begin
        if (m_st.tick) begin
          s_next.stat[IRQ_TICK] = 1'b1; // RL7
          if (s_reg.tick_cnt == TICK_LAST) begin // RL8
            s_next.tick_cnt = '0; // RL16
            s_next.stat[IRQ_STEP] = 1'b1;
            s_next.ind = !s_reg.ind; // RL11
            if (s_reg.duty_idx == IDX_LAST) begin // RL9
              s_next.duty_idx = '0;
            end else begin
              s_next.duty_idx = s_reg.duty_idx + 3'h1;
            end
            s_next.compare = compare_of(s_next.duty_idx); // RL10
          end else begin
            s_next.tick_cnt = s_reg.tick_cnt + 8'h01;
          end
        end
      end
      MSPD_IDLE: s_next.tick_cnt = s_reg.tick_cnt;
      default: s_next.run = MSPD_IDLE;
    endcase

    s_next.pwm = sl_st.out; // RL2
    s_next.pwm_oe = !s_reg.dir[DIR_PWM_BIT];
    s_next.ind_oe = !s_reg.dir[DIR_IND_BIT]; // RL13
    s_next.irq = |(s_reg.stat & s_reg.mask);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.run <= MSPD_IDLE;
      s_reg.compare <= COMPARE_RESET; // RL5
      s_reg.dir <= DIR_RESET;
      s_reg.stat <= IRQ_RESET;
      s_reg.mask <= IRQ_RESET;
      s_reg.pwm_oe <= 1'b1;
      s_reg.ind_oe <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign pwm_port_pin = s_reg.pwm;
  assign pwm_port_pin_oe = s_reg.pwm_oe;
  assign indicator_port_pin = s_reg.ind;
  assign indicator_port_pin_oe = s_reg.ind_oe;
  assign irq = s_reg.irq;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence seq_ctrl_start;
    wr_en && paddr == ADDR_CTRL && !pwdata[CTRL_STOP]
      && pwdata[CTRL_START_M] && pwdata[CTRL_START_S];
  endsequence

  sequence seq_last_tick;
    s_reg.run == MSPD_RUN && m_st.tick && s_reg.tick_cnt == TICK_LAST;
  endsequence

  sequence seq_step_done;
    s_reg.tick_cnt == '0 && s_reg.stat[IRQ_STEP];
  endsequence

  AST_START_BOTH: assert property ( // RL6
    $rose(s_reg.run == MSPD_RUN) |-> $past(wr_en && paddr == ADDR_CTRL
      && pwdata[CTRL_START_M] && pwdata[CTRL_START_S]))
    else $error("Run began without both start bits");

  AST_START_CHANS: assert property ( // RL1
    seq_ctrl_start |=> s_reg.start_p ##1 (m_st.busy && sl_st.busy && sl_st.out))
    else $error("Channels did not start together");

  AST_STEP: assert property ( // RL8
    seq_last_tick |=> seq_step_done)
    else $error("Tick count 250 did not step the duty");

  AST_NO_EARLY_STEP: assert property ( // RL16
    (s_reg.run == MSPD_RUN && m_st.tick && s_reg.tick_cnt != TICK_LAST
      && !(wr_en && paddr == ADDR_CTRL))
      |=> s_reg.tick_cnt == $past(s_reg.tick_cnt) + 8'h01 && $stable(s_reg.duty_idx))
    else $error("Tick counter misstepped");

  AST_WRAP: assert property ( // RL9
    seq_last_tick ##0 (s_reg.duty_idx == IDX_LAST) |=> s_reg.duty_idx == '0)
    else $error("Duty did not wrap after the last step");

  AST_COMPARE: assert property ( // RL10
    seq_last_tick |=> s_reg.compare == compare_of(s_reg.duty_idx))
    else $error("Compare value not loaded with the new duty");

  AST_TOGGLE: assert property ( // RL11
    seq_last_tick |=> s_reg.ind != $past(s_reg.ind) ##1 indicator_port_pin == s_reg.ind)
    else $error("Indicator did not invert on a step");

  AST_IND_HOLD: assert property ( // RL11
    !(m_st.tick && s_reg.run == MSPD_RUN) |=> $stable(s_reg.ind))
    else $error("Indicator changed without a step");

  AST_RESTART: assert property ( // RL4
    (sl_trig && !s_reg.stop_p && !s_reg.start_p) |=> sl_st.busy && sl_st.out
      && sl_st.count == $past(s_reg.compare) - 16'h0001)
    else $error("Slave not restarted by master expiry");

  AST_PWM_PIN: assert property ( // RL2
    sl_st.out |=> pwm_port_pin)
    else $error("Pin does not follow slave output");

  AST_DIR: assert property ( // RL13
    s_reg.dir[DIR_IND_BIT] == 1'b0 |=> indicator_port_pin_oe)
    else $error("Indicator buffer off with direction bit 0");

  AST_TICK_FLAG: assert property ( // RL7
    (m_st.tick && s_reg.run == MSPD_RUN) |=> s_reg.stat[IRQ_TICK] ##1 (irq
      || !$past(s_reg.mask[IRQ_TICK])))
    else $error("Tick event flag or interrupt missing");

  // Interrupt level trails the flags by one flop
  AST_IRQ_LEVEL: assert property (
    irq == $past(|(s_reg.stat & s_reg.mask)))
    else $error("Interrupt level does not follow unmasked flags");

  AST_PWM_LOW: assert property ( // RL2
    !sl_st.out |=> !pwm_port_pin)
    else $error("Pin high while slave output low");

  AST_LONE_START: assert property ( // RL6
    (wr_en && paddr == ADDR_CTRL && !(pwdata[CTRL_START_M] && pwdata[CTRL_START_S]))
      |=> !s_reg.start_p)
    else $error("Start pulse without both start bits");

  AST_MASTER_LOAD: assert property ( // RL3 RL14
    seq_ctrl_start |=> ##1 m_st.count == PERIOD_LOAD - 16'h0001)
    else $error("Master not loaded with the full period");

  AST_STOP: assert property (
    s_reg.stop_p |=> !m_st.busy && !sl_st.busy && !sl_st.out)
    else $error("Stop did not halt both channels");

  AST_RESET_DUTY: assert property ( // RL5 RL12
    s_reg.duty_idx == '0 |-> s_reg.compare == COMPARE_RESET)
    else $error("Compare differs from the ten percent value at index 0");

  AST_APB_WAIT: assert property (
    (access && !s_reg.pready) |=> pready ##1 !pready)
    else $error("Bus answer not a one-cycle pulse after one wait state");

  AST_PWM_OE: assert property (
    s_reg.dir[DIR_PWM_BIT] |=> !pwm_port_pin_oe)
    else $error("PWM buffer on with direction bit 1");

endmodule

/* File: tb/mspd_led_model.sv */
`timescale 1ns/1ps
// LED pair on the two port pins; measures PWM high time and period
module mspd_led_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pins
  input wire logic pwm_port_pin,
  input wire logic pwm_port_pin_oe,
  input wire logic indicator_port_pin,
  input wire logic indicator_port_pin_oe,
  // Observations
  output logic brightness_led,
  output logic update_indicator_led,
  output logic [31:0] hi_last,
  output logic [31:0] per_last
);
  logic prev_reg;
  logic [31:0] run_reg;
  logic [31:0] hi_reg;

  // An undriven pin leaves the LED dark
  assign brightness_led = pwm_port_pin & pwm_port_pin_oe;
  assign update_indicator_led = indicator_port_pin & indicator_port_pin_oe;

  // ****************************************
  // Width and period, latched at each rise
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 1'b0;
      run_reg <= 32'h0000_0000;
      hi_reg <= 32'h0000_0000;
      hi_last <= 32'h0000_0000;
      per_last <= 32'h0000_0000;
    end else begin
      prev_reg <= brightness_led;
      if (brightness_led && !prev_reg) begin
        per_last <= run_reg;
        hi_last <= hi_reg;
        run_reg <= 32'h0000_0001;
        hi_reg <= 32'h0000_0001;
      end else begin
        run_reg <= run_reg + 32'h0000_0001;
        hi_reg <= hi_reg + {31'h0000_0000, brightness_led};
      end
    end
  end
endmodule

/* File: tb/mspd_top_tb.sv */
`timescale 1ns/1ps
module mspd_top_tb;
  import mspd_pkg::*;
  // Short period lets all four steps and the wrap fit the run
  localparam int unsigned PER = 40;
  localparam int unsigned C10 = PER * DUTY_INIT_PCT / PCT_FULL;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, hi_last, per_last;
  logic pwm, pwm_oe, ind, ind_oe, led_b, led_u, err;
  int n_mismatch, n_checks, cyc, t_step, ce;

  mspd_top #(.PERIOD(PER)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pwm_port_pin(pwm), .pwm_port_pin_oe(pwm_oe),
    .indicator_port_pin(ind), .indicator_port_pin_oe(ind_oe), .irq(irq));
  mspd_led_model led (.pclk(pclk), .presetn(presetn), .pwm_port_pin(pwm),
    .pwm_port_pin_oe(pwm_oe), .indicator_port_pin(ind), .indicator_port_pin_oe(ind_oe),
    .brightness_led(led_b), .update_indicator_led(led_u), .hi_last(hi_last),
    .per_last(per_last));

  always #5 pclk = ~pclk;

  // ****************************************
  // Cycle ceiling against hangs
  // ****************************************
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      n_mismatch = n_mismatch + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Setup, access, then hold until pready is sampled high
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n = n + 1;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20) chk("pready", 32'h0000_0001, 32'h0000_0000);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdchk(input string name, input logic [ADDR_W-1:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(name, e, rd);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr = '0;
    pwdata = 32'h0000_0000;
    n_mismatch = 0;
    n_checks = 0;
    cyc = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // ****************************************
    // Reset state and register map
    // ****************************************
    chk("full compare", 32'h0000_1900, PERIOD_CYC * DUTY_INIT_PCT / PCT_FULL);
    chk("oe pins", 32'h0000_0003, {30'h0, pwm_oe, ind_oe});
    rdchk("dir", ADDR_PORT_DIR, 32'h0000_0000);
    rdchk("compare", ADDR_COMPARE, C10);
    rdchk("status", ADDR_STATUS, 32'h0000_0000);
    rdchk("mask", ADDR_IRQ_MASK, 32'h0000_0000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0, err});
    apb(1'b1, ADDR_PORT_DIR, 32'h0000_0041);
    repeat (2) @(posedge pclk);
    chk("oe off", 32'h0000_0000, {30'h0, pwm_oe, ind_oe});
    apb(1'b1, ADDR_PORT_DIR, 32'h0000_0000);
    $display("test reset and map done");
    // ****************************************
    // Lone start bits are refused
    // ****************************************
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    apb(1'b1, ADDR_CTRL, 32'h0000_0002);
    repeat (4) @(posedge pclk);
    rdchk("one bit start", ADDR_STATUS, 32'h0000_0000);
    chk("pwm idle", 32'h0000_0000, {31'h0, pwm});
    chk("pwm led idle", 32'h0000_0000, {31'h0, led_b});
    $display("test lone start done");
    // ****************************************
    // Running waveform and tick interrupt
    // ****************************************
    apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0001);
    apb(1'b1, ADDR_CTRL, 32'h0000_0003);
    repeat (3 * PER + 10) @(posedge pclk);
    chk("period", PER, per_last);
    chk("width 10", C10, hi_last);
    chk("irq tick", 32'h0000_0001, {31'h0, irq});
    apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0002);
    apb(1'b1, ADDR_IRQ_STAT, 32'h0000_0003);
    repeat (2) @(posedge pclk);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    $display("test run done");
    // ****************************************
    // Four duty steps 250 ticks apart, then the wrap
    // ****************************************
    for (int k = 1; k <= 5; k++) begin
      while (irq !== 1'b1) @(posedge pclk);
      if (k > 1) chk("step spacing", TICKS_PER_STEP * PER, cyc - t_step);
      t_step = cyc;
      ce = PER * (DUTY_INIT_PCT + DUTY_STEP_PCT * (k % 5)) / PCT_FULL;
      chk("indicator", k % 2, {31'h0, ind});
      chk("indicator led", k % 2, {31'h0, led_u});
      rdchk("step status", ADDR_STATUS, ((k % 2) << 4) | ((k % 5) << 1) | 1);
      rdchk("step compare", ADDR_COMPARE, ce);
      apb(1'b0, ADDR_TICKS, 32'h0000_0000);
      chk("ticks cleared", 32'h0000_0001, {31'h0, rd < 32'd5});
      repeat (2 * PER + 10) @(posedge pclk);
      chk("width step", ce, hi_last);
      chk("period kept", PER, per_last);
      // Clear the step flag and let the interrupt fall before the next wait
      apb(1'b1, ADDR_IRQ_STAT, 32'h0000_0002);
      repeat (2) @(posedge pclk);
    end
    $display("test steps and wrap done");
    apb(1'b1, ADDR_CTRL, 32'h0000_0004);
    rdchk("stopped", ADDR_STATUS, 32'h0000_0010);
    chk("pwm stopped", 32'h0000_0000, {31'h0, pwm});
    $display("test stop done");
    finish_test();
  end
endmodule
